/* spira_pkg.sv */
// Constants, types and register map of the serial register access port
package spira_pkg;

  // Register space
  localparam int unsigned ADDR_W     = 10;
  localparam int unsigned NUM_REGS   = 5;
  localparam logic [9:0] OFS_DEVICE_ACTIVE_CTRL     = 10'h000;
  localparam logic [9:0] OFS_SCAN_AND_PWM_SETUP     = 10'h001;
  localparam logic [9:0] OFS_DRIVE_CONFIG_A         = 10'h002;
  localparam logic [9:0] OFS_FAULT_COMP_CONFIG      = 10'h003;
  localparam logic [9:0] OFS_CURRENT_DEGHOST_CONFIG = 10'h004;

  localparam logic [7:0] RST_DEVICE_ACTIVE_CTRL     = 8'h00;
  localparam logic [7:0] RST_SCAN_AND_PWM_SETUP     = 8'h5e;
  localparam logic [7:0] RST_DRIVE_CONFIG_A         = 8'h00;
  localparam logic [7:0] RST_FAULT_COMP_CONFIG      = 8'h00;
  localparam logic [7:0] RST_CURRENT_DEGHOST_CONFIG = 8'h47;

  // Field positions
  localparam int unsigned DEVICE_ACTIVE_BIT = 0;
  localparam int unsigned ADDR2_HI_MSB      = 7;
  localparam int unsigned ADDR2_HI_LSB      = 6;
  localparam int unsigned DIR_BIT           = 5;
  localparam logic        DIR_WRITE         = 1'b1;

  // Serial framing
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Two-wire follower address: fixed upper bits, straps below
  localparam logic [2:0] TWO_WIRE_ADDR_PREFIX = 3'h4;

  // Serial clock limit and resulting cycles per serial clock period
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned SCLK_MAX_MHZ    = 12;
  localparam int unsigned SCLK_MIN_CYCLES = CLK_MHZ / SCLK_MAX_MHZ;

  // Strap capture delay after reset release, covers the synchroniser depth
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    SPIRA_IDLE  = 3'b000,
    SPIRA_BUS_ID_STRAP_HIGH = 3'b001,
    SPIRA_ADDR2 = 3'b010,
    SPIRA_WRITE = 3'b011,
    SPIRA_READ  = 3'b100
  } spira_state_t;

  typedef struct packed {
    logic [7:0] current_deghost_config;
    logic [7:0] fault_comp_config;
    logic [7:0] drive_config_a;
    logic [7:0] scan_and_pwm_setup;
    logic [7:0] device_active_ctrl;
  } spira_cfg_t;

  typedef struct packed {
    logic ss_n;
    logic sclk;
    logic mosi;
    logic interface_select_strap;
    logic bus_id_strap_high;
    logic bus_id_strap_low;
  } spira_pins_t;

endpackage : spira_pkg

/* spira_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module spira_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule : spira_sync

/* spira_port.sv */
// Serial host port with strap-selected mode and five configuration registers
`timescale 1ns/1ps
//
// Operation
// - Interface strap low selects two-wire follower mode; serial port stays idle.
// - Interface strap high selects the serial follower port.
// - Two-wire follower address built from the two bus id straps.
// - Serial clock up to 12 MHz; host never exceeds it.
// - Data output released whenever no read data is returned.
// - Data output driven only in a read transfer with select low.
// - Data output released throughout a write transfer.
// - Select high returns the state machine and bit counter to idle.
// - Input data sampled on each rising serial clock edge.
// - Read data shifted out on falling serial clock edges.
// - Every byte is eight bits, most significant bit first.
// - First byte holds register address bits 9 to 2.
// - Second byte: address bits 1,0, then direction bit 5, rest ignored.
// - Address advances by one after each data byte.
// - Inactive device keeps registers, only the active control register is accessible.
module spira_port
  import spira_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Serial pins
  input  wire logic       ss_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso_o,
  output logic            miso_oe_n,
  // Straps
  input  wire logic       interface_select_strap,
  input  wire logic       bus_id_strap_low,
  input  wire logic       bus_id_strap_high,
  // Mode and configuration towards the device core
  output logic            spi_mode_r,
  output logic [6:0]      two_wire_addr_r,
  output spira_cfg_t      cfg_r
);

  spira_pins_t pins_raw;
  spira_pins_t pins_s;

  assign pins_raw = '{ss_n:                   ss_n,
                      sclk:                   sclk,
                      mosi:                   mosi,
                      interface_select_strap: interface_select_strap,
                      bus_id_strap_high:      bus_id_strap_high,
                      bus_id_strap_low:       bus_id_strap_low};

  spira_sync #(
    .WIDTH ($bits(spira_pins_t))
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // Strap capture, once after reset release
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic       straps_done_r;
  logic       straps_done_nxt;
  logic       spi_mode_nxt;
  logic [6:0] two_wire_addr_nxt;

  always_comb begin
    settle_nxt        = settle_r;
    straps_done_nxt   = straps_done_r;
    spi_mode_nxt      = spi_mode_r;
    two_wire_addr_nxt = two_wire_addr_r;
    if (!straps_done_r) begin
      if (settle_r == STRAP_SETTLE) begin
        straps_done_nxt   = 1'b1;
        spi_mode_nxt      = pins_s.interface_select_strap;
        two_wire_addr_nxt = {TWO_WIRE_ADDR_PREFIX, 2'h0,
                             pins_s.bus_id_strap_high,
                             pins_s.bus_id_strap_low};
      end else begin
        settle_nxt = settle_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_r        <= 2'h0;
      straps_done_r   <= 1'b0;
      spi_mode_r      <= 1'b0;
      two_wire_addr_r <= 7'h00;
    end else begin
      settle_r        <= settle_nxt;
      straps_done_r   <= straps_done_nxt;
      spi_mode_r      <= spi_mode_nxt;
      two_wire_addr_r <= two_wire_addr_nxt;
    end
  end

  // Serial clock edge detection on the synchronised level
  logic sclk_d_r;
  logic sclk_rise;
  logic sclk_fall;

  assign sclk_rise = pins_s.sclk & ~sclk_d_r;
  assign sclk_fall = ~pins_s.sclk & sclk_d_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= pins_s.sclk;
    end
  end

  // Register access helpers
  function automatic logic [7:0] reg_read(input spira_cfg_t c, input logic [9:0] a);
    logic active;
    active = c.device_active_ctrl[DEVICE_ACTIVE_BIT];
    case (a)
      OFS_DEVICE_ACTIVE_CTRL:     reg_read = c.device_active_ctrl;
      OFS_SCAN_AND_PWM_SETUP:     reg_read = active ? c.scan_and_pwm_setup : 8'h00;
      OFS_DRIVE_CONFIG_A:         reg_read = active ? c.drive_config_a : 8'h00;
      OFS_FAULT_COMP_CONFIG:      reg_read = active ? c.fault_comp_config : 8'h00;
      OFS_CURRENT_DEGHOST_CONFIG: reg_read = active ? c.current_deghost_config : 8'h00;
      default:                    reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Serial state machine
  spira_state_t state_r;
  spira_state_t state_nxt;
  logic [2:0]   bit_cnt_r;
  logic [2:0]   bit_cnt_nxt;
  logic [7:0]   rx_r;
  logic [7:0]   rx_nxt;
  logic [7:0]   tx_r;
  logic [7:0]   tx_nxt;
  logic [9:0]   addr_r;
  logic [9:0]   addr_nxt;
  logic         miso_nxt;
  logic         miso_oe_n_nxt;
  spira_cfg_t   cfg_nxt;
  logic [7:0]   rx_byte;
  logic         byte_done;
  logic         active;

  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt      = rx_r;
    tx_nxt      = tx_r;
    addr_nxt    = addr_r;
    miso_nxt    = miso_o;
    cfg_nxt     = cfg_r;
    rx_byte     = {rx_r[6:0], pins_s.mosi};
    byte_done   = sclk_rise && (bit_cnt_r == LAST_BIT);
    active      = cfg_r.device_active_ctrl[DEVICE_ACTIVE_BIT];
    if (!spi_mode_r || pins_s.ss_n) begin
      // Idle whenever deselected or in two-wire mode
      state_nxt   = SPIRA_IDLE;
      bit_cnt_nxt = 3'h0;
      miso_nxt    = 1'b0;
    end else begin
      if (sclk_rise && state_r != SPIRA_IDLE) begin
        rx_nxt      = rx_byte;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
      end
      case (state_r)
        SPIRA_IDLE: begin
          state_nxt   = SPIRA_BUS_ID_STRAP_HIGH;
          bit_cnt_nxt = 3'h0;
        end
        SPIRA_BUS_ID_STRAP_HIGH: begin
          if (byte_done) begin
            addr_nxt  = {rx_byte, 2'h0};
            state_nxt = SPIRA_ADDR2;
          end
        end
        SPIRA_ADDR2: begin
          if (byte_done) begin
            addr_nxt = {addr_r[9:2], rx_byte[ADDR2_HI_MSB:ADDR2_HI_LSB]};
            if (rx_byte[DIR_BIT] == DIR_WRITE) begin
              state_nxt = SPIRA_WRITE;
            end else begin
              state_nxt = SPIRA_READ;
              tx_nxt    = reg_read(cfg_r,
                                   {addr_r[9:2], rx_byte[ADDR2_HI_MSB:ADDR2_HI_LSB]});
            end
          end
        end
        SPIRA_WRITE: begin
          if (byte_done) begin
            // Standby leaves only the active control register writable so settings survive
            case (addr_r)
              OFS_DEVICE_ACTIVE_CTRL: cfg_nxt.device_active_ctrl = rx_byte;
              OFS_SCAN_AND_PWM_SETUP: begin
                if (active) cfg_nxt.scan_and_pwm_setup = rx_byte;
              end
              OFS_DRIVE_CONFIG_A: begin
                if (active) cfg_nxt.drive_config_a = rx_byte;
              end
              OFS_FAULT_COMP_CONFIG: begin
                if (active) cfg_nxt.fault_comp_config = rx_byte;
              end
              OFS_CURRENT_DEGHOST_CONFIG: begin
                if (active) cfg_nxt.current_deghost_config = rx_byte;
              end
              default: begin
              end
            endcase
            addr_nxt = addr_r + 10'h001;
          end
        end
        SPIRA_READ: begin
          if (sclk_fall) begin
            miso_nxt = tx_r[7];
            tx_nxt   = {tx_r[6:0], 1'b0};
          end
          if (byte_done) begin
            addr_nxt = addr_r + 10'h001;
            tx_nxt   = reg_read(cfg_r, addr_r + 10'h001);
          end
        end
        default: begin
          state_nxt = SPIRA_IDLE;
        end
      endcase
    end
    miso_oe_n_nxt = ~(state_nxt == SPIRA_READ);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= SPIRA_IDLE;
      bit_cnt_r <= 3'h0;
      rx_r      <= 8'h00;
      tx_r      <= 8'h00;
      addr_r    <= 10'h000;
      miso_o    <= 1'b0;
      miso_oe_n <= 1'b1;
      cfg_r     <= '{current_deghost_config: RST_CURRENT_DEGHOST_CONFIG,
                     fault_comp_config:      RST_FAULT_COMP_CONFIG,
                     drive_config_a:         RST_DRIVE_CONFIG_A,
                     scan_and_pwm_setup:     RST_SCAN_AND_PWM_SETUP,
                     device_active_ctrl:     RST_DEVICE_ACTIVE_CTRL};
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_r      <= rx_nxt;
      tx_r      <= tx_nxt;
      addr_r    <= addr_nxt;
      miso_o    <= miso_nxt;
      miso_oe_n <= miso_oe_n_nxt;
      cfg_r     <= cfg_nxt;
    end
  end

endmodule : spira_port

/* spira_props.sv */
// Checker for the serial register access port
`timescale 1ns/1ps
module spira_props
  import spira_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Serial pins
  input wire logic       ss_n,
  input wire logic       sclk,
  input wire logic       mosi,
  input wire logic       miso_o,
  input wire logic       miso_oe_n,
  // Straps and outputs
  input wire logic       interface_select_strap,
  input wire logic       bus_id_strap_low,
  input wire logic       bus_id_strap_high,
  input wire logic       spi_mode_r,
  input wire logic [6:0] two_wire_addr_r,
  input wire spira_cfg_t cfg_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  // Edges since reset release, saturating so the strap capture check fires once
  always_comb cnt_nxt = (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) cnt_r <= 4'h0;
    else cnt_r <= cnt_nxt;
  a_oe_in_frame: assert property (!miso_oe_n |-> !$past(ss_n, 5))
    else $error("data output driven outside a frame");
  a_miso_idle_zero: assert property (miso_oe_n |-> !miso_o)
    else $error("data output value not zero while released");
  a_ss_release: assert property ($rose(ss_n) |-> ##[1:5] miso_oe_n)
    else $error("data output not released after select high");
  a_mode_fixed:
    assert property (cnt_r >= 4'h6 |-> $stable({spi_mode_r, two_wire_addr_r}))
    else $error("strap capture changed after settling");
  a_strap_capture:
    assert property (cnt_r == 4'h8 |-> {spi_mode_r, two_wire_addr_r} ==
      {$past(interface_select_strap, 6), 5'h10, $past(bus_id_strap_high, 6),
       $past(bus_id_strap_low, 6)})
    else $error("captured mode or address does not match the straps");
  a_cfg_idle_hold: assert property (ss_n && $past(ss_n, 6) |-> $stable(cfg_r))
    else $error("configuration changed outside a frame");
  a_standby_gate:
    assert property (!cfg_r[0] && !$past(cfg_r[0]) |-> $stable(cfg_r[39:8]))
    else $error("gated register written in standby");
  a_miso_on_fall:
    assert property ($changed(miso_o) && !miso_oe_n && !$past(miso_oe_n)
      |-> !sclk && !$past(sclk, 3))
    else $error("read data changed away from a falling serial clock");
  cover property (!miso_oe_n ##1 miso_oe_n);
  cover property ($changed(cfg_r));
  cover property (cnt_r == 4'h8 && !spi_mode_r);
endmodule : spira_props

bind spira_port spira_props props_u (.clk, .reset_n, .ss_n, .sclk, .mosi, .miso_o,
  .miso_oe_n, .interface_select_strap, .bus_id_strap_low, .bus_id_strap_high,
  .spi_mode_r, .two_wire_addr_r, .cfg_r);

/* spira_host.sv */
// Host serial controller model: select, clock and data towards the port
`timescale 1ns/1ps
module spira_host #(
  parameter int H = 12
) (
  input  wire logic clk,
  input  wire logic miso,
  output logic      ss_n,
  output logic      sclk,
  output logic      mosi
);
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Half period of H cycles gives about 10 MHz, under the serial limit
  task automatic shift8(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) mosi <= tx[i];
      repeat (H) @(posedge clk);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (H) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask : shift8
  task automatic xfer(input logic [9:0] a, input logic wr, input int n,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [7:0] b;
    rd = 16'h0000;
    @(posedge clk) ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    shift8(a[9:2], b);
    shift8({a[1:0], wr, 5'h00}, b);
    for (int k = n - 1; k >= 0; k--) begin
      shift8(wd[8*k +: 8], b);
      rd[8*k +: 8] = b;
    end
    repeat (H) @(posedge clk);
    ss_n <= 1'b1;
    // Data line no longer holds the last bit once deselected
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask : xfer
  // Frame cut after a few bits, leaves a partial byte behind
  task automatic frag(input int nb);
    @(posedge clk) ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk) mosi <= 1'b1;
      repeat (H) @(posedge clk);
      sclk <= 1'b1;
      repeat (H) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (H) @(posedge clk);
    ss_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : frag
endmodule : spira_host

/* testbench.sv */
// Self-checking bench for the serial register access port
`timescale 1ns/1ps
module testbench;
  import spira_pkg::*;
  typedef struct packed {logic [9:0] a; logic wr; logic [7:0] d;} spira_row_t;
  logic       clk, reset_n, strap, ss_n, sclk, mosi, miso_o, miso_oe_n, miso_last, spi_mode_r;
  logic [1:0] ids;
  logic [6:0] two_wire_addr_r;
  logic [15:0] rd;
  spira_cfg_t cfg_r, sh;
  int         mismatches, total_checks, cyc, oe_cnt;
  // Write rows carry data, read rows the expected byte
  spira_row_t rows[9] = '{'{10'h001, 1'b0, 8'h00}, '{10'h000, 1'b1, 8'h01},
    '{10'h000, 1'b0, 8'h01}, '{10'h001, 1'b0, 8'h5e}, '{10'h004, 1'b0, 8'h47},
    '{10'h002, 1'b1, 8'ha5}, '{10'h002, 1'b0, 8'ha5}, '{10'h3ff, 1'b0, 8'h00},
    '{10'h005, 1'b1, 8'h77}};
  spira_host host_u (.clk(clk), .miso(miso_oe_n ? ~miso_last : miso_o), .ss_n(ss_n),
    .sclk(sclk), .mosi(mosi));
  spira_port dut_u (.clk(clk), .reset_n(reset_n), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .interface_select_strap(strap),
    .bus_id_strap_low(ids[0]), .bus_id_strap_high(ids[1]), .spi_mode_r(spi_mode_r),
    .two_wire_addr_r(two_wire_addr_r), .cfg_r(cfg_r));
  task automatic chk(string n, logic [39:0] seen, logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic run(logic [9:0] a, logic wr, int n, logic [15:0] d);
    int c0;
    c0 = oe_cnt;
    host_u.xfer(a, wr, n, d, rd);
    chk("oe_frame", oe_cnt != c0, !wr && strap);
    chk("oe_idle", miso_oe_n, 1'b1);
    for (int k = 0; k < n; k++)
      if (wr && a + k < 5 && (a + k == 0 || sh[0])) sh[8*(a+k) +: 8] = d[8*(n-1-k) +: 8];
  endtask : run
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    miso_last <= miso_oe_n ? miso_last : miso_o;
    cyc <= cyc + 1;
    if (!miso_oe_n) oe_cnt <= oe_cnt + 1;
    if (cyc == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    strap = 1'b1;
    ids = 2'h2;
    cyc = 0;
    miso_last = 1'b0;
    sh = 40'h47_0000_5e00;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    chk("cfg_reset", cfg_r, sh);
    repeat (10) @(posedge clk);
    chk("mode", spi_mode_r, 1'b1);
    chk("bus_addr", two_wire_addr_r, 7'h42);
    foreach (rows[i]) begin
      run(rows[i].a, rows[i].wr, 1, {8'h00, rows[i].d});
      if (rows[i].wr) chk("cfg", cfg_r, sh);
      else chk("read", rd[7:0], rows[i].d);
    end
    run(10'h003, 1'b1, 2, 16'h3c5a);
    chk("burst_wr", cfg_r, sh);
    run(10'h003, 1'b0, 2, 16'h0000);
    chk("burst_rd", rd, 16'h3c5a);
    run(10'h000, 1'b1, 1, 16'h0000);
    run(10'h001, 1'b1, 1, 16'h00ff);
    chk("standby_wr", cfg_r, sh);
    run(10'h004, 1'b0, 1, 16'h0000);
    chk("standby_rd", rd[7:0], 8'h00);
    // Address-only frame must leave nothing pending for the next frame
    run(10'h001, 1'b1, 0, 16'h0000);
    run(10'h000, 1'b1, 1, 16'h0001);
    chk("after_abort", cfg_r, sh);
    host_u.frag(3);
    run(10'h000, 1'b1, 1, 16'h0000);
    chk("after_cut", cfg_r, sh);
    strap <= 1'b0;
    ids <= 2'h1;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("mode_off", spi_mode_r, 1'b0);
    chk("bus_addr_b", two_wire_addr_r, 7'h41);
    run(10'h000, 1'b1, 1, 16'h0001);
    sh = 40'h47_0000_5e00;
    chk("spi_ignored", cfg_r, sh);
    stop_test();
  end
endmodule : testbench
